// ---- rtl/csd_decoder.sv ----
// Bank select decoder: address match, permissions, termination and select timing
// Functional notes
// - Eight bank selects, each with origin, ignore and control registers.
// - Compare address bits 31:16 with origin, skipping ignored bits.
// - No ignore bits set gives a 64 kbyte bank.
// - Priority: bank 0 first, banks 1 to 7, DRAM 0, DRAM 1, default.
// - No match: default settings apply, no select or DRAM hit asserted.
// - Each bank has read-allow and write-allow bits gating its response.
// - Four attribute masks per bank; only bank 1 may take CPU space.
// - Outside boot, select asserts only with address match, allowed direction, unmasked attribute.
// - Banks and default have a wait count from zero to fifteen.
// - Port width selects 8, 16 or 32 bit lanes from the top.
// - Core transfers end in the cycle an external sync acknowledge arrives.
// - Alternate master transfers with internal termination: device drives the acknowledge.
// - Synchronized async acknowledge ends core bank or default transfers early.
// - Alternate master transfers may end early by synchronized async acknowledge.
// - Burst when enabled and operand wider than port; otherwise single transfers.
// - Select asserts the cycle after the start strobe, or one cycle later if setup.
// - Per bank option keeps select asserted between burst beats.
// - Hold option keeps address, attributes and write data one more cycle.
// - Bank 1 can be programmed to assert on CPU space accesses.
// - After reset bank 0 selects every non CPU space access.
// - Internal termination enabled per bank and default, each with own count.
// - Each bank has an enable to drive the acknowledge for alternate masters.
// - Boot behaviour ends at first write to bank 0 ignore register.
// - Boot bank width and auto acknowledge come from straps sampled in reset.
// - Byte write strobes follow the select by one cycle on writes.
// - With setup, zero wait writes give no byte write strobes.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module csd_decoder (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Register port
  input wire logic [csd_pkg::CSD_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Transfer request from the bus
  input wire logic cycle_start_strobe,
  input wire logic [31:0] xfer_addr,
  input wire logic xfer_rd,
  input wire logic [1:0] xfer_size,
  input wire logic attr_super,
  input wire logic attr_code,
  input wire logic attr_cpu,
  input wire logic alt_master,
  // Acknowledges and straps
  input wire logic sync_transfer_ack,
  input wire logic async_ack_in,
  input wire logic [2:0] boot_strap_pin,
  // Memory side controls
  output logic [7:0] bank_sel,
  output logic [1:0] dram_hit,
  output logic [3:0] byte_we,
  output logic [1:0] port_width,
  output logic burst_xfer,
  output logic xfer_done,
  output logic sync_ack_out,
  output logic sync_ack_oe,
  output logic addr_hold
);
  import csd_pkg::*;

  csd_state_s st;
  csd_state_s nxt;
  logic [7:0] bank_ok;
  logic [1:0] dram_ok;
  logic found;
  logic [2:0] idx;
  logic [13:0] hctl;
  logic [1:0] hpw;
  logic hauto;
  logic go;
  logic go_setup;
  logic term;
  logic int_en;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic addr_match(input logic [15:0] a, input logic [15:0] org,
                                      input logic [15:0] ign);
    addr_match = ((a ^ org) & ~ign) == 16'h0000;
  endfunction

  function automatic logic [3:0] lanes_f(input logic [1:0] pw, input logic [1:0] sz,
                                         input logic [1:0] a);
    lanes_f = 4'hF;
    if (pw == PW_8) begin
      lanes_f = 4'h8;
    end else if (pw == PW_16) begin
      lanes_f = 4'hC;
    end else if (sz == SZ_BYTE) begin
      lanes_f = 4'(4'h8 >> a);
    end else if (sz == SZ_WORD) begin
      lanes_f = a[1] ? 4'h3 : 4'hC;
    end
  endfunction

  function automatic logic [3:0] beats_f(input logic [1:0] pw, input logic [1:0] sz);
    logic [4:0] ob;
    logic [4:0] pb;
    ob = (sz == SZ_BYTE) ? 5'h01 : (sz == SZ_WORD) ? 5'h02 : (sz == SZ_LONG) ? 5'h04 : 5'h10;
    pb = (pw == PW_8) ? 5'h01 : (pw == PW_16) ? 5'h02 : 5'h04;
    beats_f = 4'h0;
    if (ob > pb) begin
      beats_f = 4'((ob / pb) - 5'h01);
    end
  endfunction

  function automatic logic attr_ok(input logic [8:0] m, input logic bank1, input logic cpu,
                                   input logic sup, input logic code);
    if (cpu) begin
      attr_ok = bank1 && !m[MSK_CPU];
    end else if (sup) begin
      attr_ok = code ? !m[MSK_SC] : !m[MSK_SD];
    end else begin
      attr_ok = code ? !m[MSK_UC] : !m[MSK_UD];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode in fixed priority
  always_comb begin
    bank_ok = 8'h00;
    dram_ok = 2'h0;
    found = 1'b0;
    idx = 3'h0;
    for (int i = 0; i < CSD_NBANK; i++) begin
      bank_ok[i] = addr_match(xfer_addr[31:16], st.origin[i], st.ignore[i])
        && (xfer_rd ? st.ctrl[i][CTL_RD] : st.ctrl[i][CTL_WR])
        && attr_ok(st.amask[i], i == 1, attr_cpu, attr_super, attr_code);
    end
    if (st.boot) begin
      bank_ok[0] = !attr_cpu && (xfer_rd ? st.ctrl[0][CTL_RD] : st.ctrl[0][CTL_WR]);
    end
    // Scan downward so that the lowest matching index wins
    for (int i = CSD_NBANK - 1; i >= 0; i--) begin
      if (bank_ok[i]) begin
        found = 1'b1;
        idx = 3'(i);
      end
    end
    if (!found) begin
      // DRAM banks are looked at only when no bank select matched
      for (int i = 0; i < CSD_NDRAM; i++) begin
        dram_ok[i] = st.den[i] && addr_match(xfer_addr[31:16], st.dorg[i], st.dign[i]);
      end
      if (dram_ok[0]) begin
        dram_ok[1] = 1'b0;
      end
    end
    hctl = found ? st.ctrl[idx] : st.fb_ctrl;
    hpw = hctl[CTL_PW_LSB +: 2];
    hauto = hctl[CTL_AUTO];
    if (found && idx == 3'h0 && st.boot) begin
      hpw = st.strap[STRAP_PW_LSB +: 2];
      hauto = st.strap[STRAP_AUTO];
    end
    go = (st.fsm == CSD_IDLE) && cycle_start_strobe && (dram_ok == 2'h0);
    go_setup = go && found && hctl[CTL_SETUP];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt = st;
    nxt.done = 1'b0;
    nxt.ack_out = 1'b0;
    nxt.dram_hit = 2'h0;
    nxt.rdata = 32'h0000_0000;
    nxt.async_s1 = async_ack_in;
    nxt.async_s2 = st.async_s1;
    int_en = st.is_alt ? st.alt_en : st.auto_en;
    term = (!st.is_alt && sync_transfer_ack)
      || st.async_s2
      || (int_en && st.wcnt == st.wait_lim);
    // Register writes
    if (reg_wr) begin
      if (reg_addr >= CSD_ORG_BASE && reg_addr < CSD_IGN_BASE) begin
        nxt.origin[reg_addr[4:2]] = reg_wdata[31:16];
      end else if (reg_addr >= CSD_IGN_BASE && reg_addr < CSD_CTL_BASE) begin
        nxt.ignore[reg_addr[4:2]] = reg_wdata[31:16];
        nxt.amask[reg_addr[4:2]] = reg_wdata[8:0];
        if (reg_addr[4:2] == 3'h0) begin
          nxt.boot = 1'b0;
        end
      end else if (reg_addr >= CSD_CTL_BASE && reg_addr < CSD_FB_CTL) begin
        nxt.ctrl[reg_addr[4:2]] = reg_wdata[13:0];
      end else if (reg_addr == CSD_FB_CTL) begin
        nxt.fb_ctrl = reg_wdata[13:0];
      end else if (reg_addr >= CSD_DORG_BASE && reg_addr < CSD_DIGN_BASE) begin
        // DRAM 0 origin sits at the lower offset
        nxt.dorg[reg_addr[2] ^ 1'b1] = reg_wdata[31:16];
      end else if (reg_addr >= CSD_DIGN_BASE && reg_addr < CSD_STATUS) begin
        nxt.dign[reg_addr[2] ^ 1'b1] = reg_wdata[31:16];
        nxt.den[reg_addr[2] ^ 1'b1] = reg_wdata[DIGN_EN];
      end
    end
    // Register reads, data valid the next cycle only
    if (reg_rd) begin
      if (reg_addr >= CSD_ORG_BASE && reg_addr < CSD_IGN_BASE) begin
        nxt.rdata = {st.origin[reg_addr[4:2]], 16'h0000};
      end else if (reg_addr >= CSD_IGN_BASE && reg_addr < CSD_CTL_BASE) begin
        nxt.rdata = {st.ignore[reg_addr[4:2]], 7'h00, st.amask[reg_addr[4:2]]};
      end else if (reg_addr >= CSD_CTL_BASE && reg_addr < CSD_FB_CTL) begin
        nxt.rdata = {18'h00000, st.ctrl[reg_addr[4:2]]};
      end else if (reg_addr == CSD_FB_CTL) begin
        nxt.rdata = {18'h00000, st.fb_ctrl};
      end else if (reg_addr >= CSD_DORG_BASE && reg_addr < CSD_DIGN_BASE) begin
        nxt.rdata = {st.dorg[reg_addr[2] ^ 1'b1], 16'h0000};
      end else if (reg_addr >= CSD_DIGN_BASE && reg_addr < CSD_STATUS) begin
        nxt.rdata = {st.dign[reg_addr[2] ^ 1'b1], 15'h0000, st.den[reg_addr[2] ^ 1'b1]};
      end else if (reg_addr == CSD_STATUS) begin
        nxt.rdata = {21'h000000, st.strap, st.boot, st.hit_bank, st.fsm, st.wcnt[3:0]};
      end
    end
    // Transfer sequencing
    case (st.fsm)
      CSD_IDLE: begin
        nxt.sel = 8'h00;
        nxt.we = 4'h0;
        nxt.hold_out = 1'b0;
        nxt.ack_oe = 1'b0;
        if (cycle_start_strobe && dram_ok != 2'h0) begin
          nxt.dram_hit = dram_ok;
        end
        if (go) begin
          nxt.hit_bank = found;
          nxt.hit_idx = idx;
          nxt.wcnt = 4'h0;
          nxt.wait_lim = hctl[CTL_WAIT_LSB +: 4];
          nxt.auto_en = hauto;
          nxt.alt_en = hctl[CTL_ALT];
          nxt.setup = found && hctl[CTL_SETUP];
          nxt.hold = hctl[CTL_HOLD];
          nxt.keep = hctl[CTL_KEEP];
          nxt.is_wr = !xfer_rd;
          nxt.is_alt = alt_master;
          nxt.pw = hpw;
          nxt.burst = hctl[CTL_BURST] && beats_f(hpw, xfer_size) != 4'h0;
          nxt.beats_left = hctl[CTL_BURST] ? beats_f(hpw, xfer_size) : 4'h0;
          nxt.lanes = lanes_f(hpw, xfer_size, xfer_addr[1:0]);
          nxt.ack_oe = alt_master && hctl[CTL_ALT];
          if (go_setup) begin
            nxt.fsm = CSD_SETUP;
          end else begin
            nxt.fsm = CSD_ACT;
            nxt.sel = found ? 8'(8'h01 << idx) : 8'h00;
          end
        end
      end
      CSD_SETUP: begin
        nxt.fsm = CSD_ACT;
        nxt.sel = st.hit_bank ? 8'(8'h01 << st.hit_idx) : 8'h00;
      end
      CSD_ACT: begin
        if (st.wcnt != 4'hF) begin
          nxt.wcnt = st.wcnt + 4'h1;
        end
        nxt.we = (st.is_wr && st.sel != 8'h00 && !(st.setup && st.wait_lim == 4'h0))
          ? st.lanes : 4'h0;
        if (term) begin
          nxt.done = 1'b1;
          nxt.ack_out = st.is_alt && st.alt_en;
          nxt.we = 4'h0;
          nxt.wcnt = 4'h0;
          if (st.beats_left != 4'h0) begin
            nxt.beats_left = st.beats_left - 4'h1;
            if (!st.keep) begin
              nxt.sel = 8'h00;
              nxt.fsm = CSD_SETUP;
            end
          end else if (st.hold) begin
            nxt.fsm = CSD_HOLD;
            nxt.hold_out = 1'b1;
          end else begin
            nxt.fsm = CSD_IDLE;
            nxt.sel = 8'h00;
            nxt.burst = 1'b0;
            // Output enable drops in idle, after the acknowledge pulse
          end
        end
      end
      CSD_HOLD: begin
        nxt.fsm = CSD_IDLE;
        nxt.sel = 8'h00;
        nxt.hold_out = 1'b0;
        nxt.burst = 1'b0;
        nxt.ack_oe = 1'b0;
      end
      default: begin
        nxt.fsm = CSD_IDLE;
      end
    endcase
    // Reset values; straps follow the pins while reset is held
    if (srst) begin
      nxt = '0;
      nxt.fsm = CSD_IDLE;
      nxt.boot = 1'b1;
      nxt.ctrl[0] = CTL0_RST;
      for (int i = 1; i < CSD_NBANK; i++) begin
        nxt.ctrl[i] = CTL_RST;
      end
      nxt.fb_ctrl = FB_CTL_RST;
      nxt.strap = boot_strap_pin;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || ce) begin
      st <= nxt;
    end
  end

  assign reg_rdata = st.rdata;
  assign bank_sel = st.sel;
  assign dram_hit = st.dram_hit;
  assign byte_we = st.we;
  assign port_width = st.pw;
  assign burst_xfer = st.burst;
  assign xfer_done = st.done;
  assign sync_ack_out = st.ack_out;
  assign sync_ack_oe = st.ack_oe;
  assign addr_hold = st.hold_out;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst || !ce);

  sequence setup_gap_s;
    (bank_sel == 8'h00) ##1 (bank_sel != 8'h00);
  endsequence

  sequence hold_step_s;
    addr_hold ##1 !addr_hold;
  endsequence

  sel_onehot_a: assert property ($onehot0(bank_sel))
    else $error("more than one bank select asserted");
  default_nosel_a: assert property ((st.fsm == CSD_ACT && !st.hit_bank) |-> bank_sel == 8'h00)
    else $error("select asserted on default region");
  setup_delay_a: assert property (go_setup |=> setup_gap_s)
    else $error("setup select timing wrong");
  nosetup_sel_a: assert property ((go && found && !go_setup) |=> bank_sel == 8'(8'h01 << $past(idx)))
    else $error("select not asserted after start");
  we_after_sel_a: assert property ($rose(byte_we != 4'h0) |-> $past(bank_sel != 8'h00))
    else $error("write strobe without prior select");
  we_zero_wait_a: assert property ((byte_we != 4'h0) |-> !(st.setup && st.wait_lim == 4'h0))
    else $error("write strobe on zero wait setup write");
  boot_clear_a: assert property ((reg_wr && reg_addr == CSD_IGN_BASE) |=> !st.boot)
    else $error("boot select survived ignore write");
  wait_term_a: assert property ((st.fsm == CSD_ACT && int_en && st.wcnt == st.wait_lim)
    |=> xfer_done)
    else $error("internal termination missed");
  sync_term_a: assert property ((st.fsm == CSD_ACT && !st.is_alt && sync_transfer_ack)
    |=> xfer_done)
    else $error("sync acknowledge did not end transfer");
  async_term_a: assert property ((st.fsm == CSD_ACT && st.async_s2) |=> xfer_done)
    else $error("async acknowledge did not end transfer");
  hold_cycle_a: assert property ((st.fsm == CSD_ACT && term && st.beats_left == 4'h0 && st.hold)
    |=> hold_step_s)
    else $error("hold cycle missing or too long");
  alt_drive_a: assert property ((st.fsm == CSD_ACT && st.is_alt && st.alt_en) |-> sync_ack_oe)
    else $error("acknowledge not driven for alternate master");
  ack_oe_cover_a: assert property (sync_ack_out |-> sync_ack_oe)
    else $error("acknowledge pulse not driven");
endmodule

// ---- rtl/csd_pkg.sv ----
// Constants, state encodings and the state record of the bank select decoder
package csd_pkg;
  localparam int CSD_NBANK = 8;
  localparam int CSD_NDRAM = 2;
  localparam int CSD_AW = 8;
  // Register offsets (byte addresses)
  localparam logic [7:0] CSD_ORG_BASE = 8'h00;
  localparam logic [7:0] CSD_IGN_BASE = 8'h20;
  localparam logic [7:0] CSD_CTL_BASE = 8'h40;
  localparam logic [7:0] CSD_FB_CTL = 8'h60;
  localparam logic [7:0] CSD_DORG_BASE = 8'h64;
  localparam logic [7:0] CSD_DIGN_BASE = 8'h6C;
  localparam logic [7:0] CSD_STATUS = 8'h74;
  // Control register fields
  localparam int CTL_WAIT_LSB = 0;
  localparam int CTL_PW_LSB = 4;
  localparam int CTL_AUTO = 6;
  localparam int CTL_ALT = 7;
  localparam int CTL_BURST = 8;
  localparam int CTL_SETUP = 9;
  localparam int CTL_HOLD = 10;
  localparam int CTL_KEEP = 11;
  localparam int CTL_RD = 12;
  localparam int CTL_WR = 13;
  localparam int CTL_W = 14;
  // Ignore register fields
  localparam int IGN_LSB = 16;
  localparam int MSK_UD = 1;
  localparam int MSK_UC = 2;
  localparam int MSK_SD = 5;
  localparam int MSK_SC = 6;
  localparam int MSK_CPU = 8;
  localparam int DIGN_EN = 0;
  // Port width codes
  localparam logic [1:0] PW_32 = 2'h0;
  localparam logic [1:0] PW_8 = 2'h1;
  localparam logic [1:0] PW_16 = 2'h2;
  // Operand size codes
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;
  // Strap layout: bit 0 automatic acknowledge, bits 2:1 port width
  localparam int STRAP_AUTO = 0;
  localparam int STRAP_PW_LSB = 1;
  // Values after reset
  localparam logic [13:0] CTL0_RST = 14'h360F;
  localparam logic [13:0] CTL_RST = 14'h0000;
  localparam logic [13:0] FB_CTL_RST = 14'h004F;

  typedef enum logic [1:0] {
    CSD_IDLE = 2'h0,
    CSD_SETUP = 2'h1,
    CSD_ACT = 2'h3,
    CSD_HOLD = 2'h2
  } csd_fsm_e;

  typedef struct packed {
    logic [7:0][15:0] origin;
    logic [7:0][15:0] ignore;
    logic [7:0][8:0] amask;
    logic [7:0][13:0] ctrl;
    logic [13:0] fb_ctrl;
    logic [1:0][15:0] dorg;
    logic [1:0][15:0] dign;
    logic [1:0] den;
    logic boot;
    logic [2:0] strap;
    csd_fsm_e fsm;
    logic hit_bank;
    logic [2:0] hit_idx;
    logic [3:0] wcnt;
    logic [3:0] wait_lim;
    logic auto_en;
    logic alt_en;
    logic setup;
    logic hold;
    logic keep;
    logic is_wr;
    logic is_alt;
    logic [3:0] beats_left;
    logic [3:0] lanes;
    logic [7:0] sel;
    logic [3:0] we;
    logic [1:0] pw;
    logic burst;
    logic done;
    logic ack_out;
    logic ack_oe;
    logic hold_out;
    logic [1:0] dram_hit;
    logic [31:0] rdata;
    logic async_s1;
    logic async_s2;
  } csd_state_s;
endpackage

// ---- tb/csd_mem_model.sv ----
// External memory model that answers a selected bank with a synchronous acknowledge
`timescale 1ns/1ps
module csd_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Memory side
  input wire logic [7:0] bank_sel,
  input wire logic alt_master,
  output logic sync_transfer_ack,
  // Model control
  input wire logic ack_en,
  input wire logic [3:0] ack_lat
);
  logic [3:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////////////
  // Acknowledge after ack_lat plus one selected cycles, never for an alternate master
  always_ff @(posedge clk) begin
    if (srst || bank_sel == 8'h00) begin
      cnt_r <= 4'h0;
      sync_transfer_ack <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      sync_transfer_ack <= ack_en && !alt_master && cnt_r == ack_lat;
    end
  end
endmodule

// ---- tb/tb_chip_select_decoder.sv ----
// Self-checking testbench of the bank select decoder
`timescale 1ns/1ps
module tb_chip_select_decoder;
  import csd_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic strb = 1'b0;
  logic [31:0] xaddr = 32'h0;
  logic xrd = 1'b0;
  logic sup = 1'b1;
  logic alt = 1'b0;
  logic aack = 1'b0;
  logic ack, ack_en = 1'b0;
  logic [3:0] ack_lat = 4'h0;
  logic [2:0] strap = 3'h1;
  logic [7:0] bank_sel;
  logic [1:0] dram_hit, port_width;
  logic [3:0] byte_we;
  logic burst_xfer, xfer_done, sync_ack_out, sync_ack_oe, addr_hold;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int cyc, cyc_a;
  logic [7:0] sel_seen;
  logic [3:0] we_seen;
  logic hold_seen;
  logic burst_seen, ack_seen;
  logic [1:0] dram_seen;
  logic [31:0] rd_val;

  always #2 clk = ~clk;

  csd_decoder uut (
    .clk(clk), .srst(srst), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cycle_start_strobe(strb), .xfer_addr(xaddr), .xfer_rd(xrd), .xfer_size(SZ_LONG),
    .attr_super(sup), .attr_code(1'b0), .attr_cpu(1'b0), .alt_master(alt),
    .sync_transfer_ack(ack), .async_ack_in(aack), .boot_strap_pin(strap),
    .bank_sel(bank_sel), .dram_hit(dram_hit), .byte_we(byte_we), .port_width(port_width),
    .burst_xfer(burst_xfer), .xfer_done(xfer_done), .sync_ack_out(sync_ack_out),
    .sync_ack_oe(sync_ack_oe), .addr_hold(addr_hold)
  );

  csd_mem_model mem (
    .clk(clk), .srst(srst), .bank_sel(bank_sel), .alt_master(alt),
    .sync_transfer_ack(ack), .ack_en(ack_en), .ack_lat(ack_lat)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port and transfer tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd_val = reg_rdata;
  endtask

  // Counts cycles from the strobe to the done pulse, collecting select and lanes
  task automatic xfer(input logic [31:0] a, input logic r);
    @(posedge clk);
    strb <= 1'b1;
    xaddr <= a;
    xrd <= r;
    @(posedge clk);
    strb <= 1'b0;
    sel_seen = 8'h00;
    we_seen = 4'h0;
    hold_seen = 1'b0;
    burst_seen = 1'b0;
    ack_seen = 1'b0;
    dram_seen = 2'h0;
    cyc = 0;
    for (int i = 1; i < 40 && cyc == 0; i++) begin
      @(negedge clk);
      sel_seen |= bank_sel;
      we_seen |= byte_we;
      burst_seen |= burst_xfer;
      ack_seen |= sync_ack_out & sync_ack_oe;
      dram_seen |= dram_hit;
      if (xfer_done === 1'b1) begin
        cyc = i;
        hold_seen = addr_hold;
      end
    end
    @(negedge clk);
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(CSD_CTL_BASE);
    chk(rd_val, {18'h0, CTL0_RST});
    rd(CSD_FB_CTL);
    chk(rd_val, {18'h0, FB_CTL_RST});
    rd(8'h80);
    chk(rd_val, 32'h0);
    // Boot bank takes any address, with setup, wait 15 and hold
    xfer(32'hABCD_0000, 1'b0);
    chk(sel_seen, 8'h01);
    chk(cyc, 18);
    chk(hold_seen, 1'b1);
    wr(CSD_CTL_BASE, 32'h3641);
    wr(CSD_ORG_BASE + 8'h08, 32'h1234_0000);
    wr(CSD_CTL_BASE + 8'h08, 32'h3041);
    wr(CSD_ORG_BASE + 8'h0C, 32'h1234_0000);
    wr(CSD_CTL_BASE + 8'h0C, 32'h3041);
    wr(CSD_ORG_BASE + 8'h10, 32'h0004_0000);
    wr(CSD_IGN_BASE + 8'h10, 32'h0003_0000);
    wr(CSD_CTL_BASE + 8'h10, 32'h3040);
    wr(CSD_ORG_BASE + 8'h14, 32'h0050_0000);
    wr(CSD_CTL_BASE + 8'h14, 32'h3000);
    wr(CSD_ORG_BASE + 8'h18, 32'h0060_0000);
    wr(CSD_CTL_BASE + 8'h18, 32'h3240);
    wr(CSD_IGN_BASE, 32'h0);
    rd(CSD_ORG_BASE + 8'h08);
    chk(rd_val, 32'h1234_0000);
    // Boot mode over: unmatched address goes to the default region
    xfer(32'hABCD_0000, 1'b0);
    chk(sel_seen, 8'h00);
    chk(we_seen, 4'h0);
    chk(cyc, 17);
    // Two banks on one origin: the lower index wins
    xfer(32'h1234_0010, 1'b0);
    chk(sel_seen, 8'h04);
    chk(we_seen, 4'hF);
    chk(cyc, 3);
    // Ignored origin bits widen the match
    xfer(32'h0007_FFFC, 1'b1);
    chk(sel_seen, 8'h10);
    chk(cyc, 2);
    xfer(32'h0008_0000, 1'b1);
    chk(sel_seen, 8'h00);
    xfer(32'h0001_0000, 1'b1);
    chk(sel_seen, 8'h00);
    xfer(32'h0000_FFFC, 1'b1);
    chk(sel_seen, 8'h01);
    chk(cyc, 4);
    // Write-only bank lets a read fall through to the next bank
    wr(CSD_CTL_BASE + 8'h08, 32'h2041);
    xfer(32'h1234_0000, 1'b1);
    chk(sel_seen, 8'h08);
    // Masked user data transfers are refused
    wr(CSD_IGN_BASE + 8'h0C, 32'h0000_0002);
    sup <= 1'b0;
    xfer(32'h1234_0000, 1'b1);
    chk(sel_seen, 8'h00);
    sup <= 1'b1;
    // Setup with zero wait on a write gives no lane strobes
    xfer(32'h0060_0000, 1'b0);
    chk(sel_seen, 8'h40);
    chk(we_seen, 4'h0);
    chk(cyc, 3);
    // External acknowledge, prompt and slow, ends a bank without auto
    ack_en <= 1'b1;
    ack_lat <= 4'h1;
    xfer(32'h0050_0000, 1'b1);
    cyc_a = cyc;
    chk(sel_seen, 8'h20);
    ack_lat <= 4'h5;
    xfer(32'h0050_0000, 1'b1);
    chk(cyc - cyc_a, 4);
    chk(cyc > 0, 1'b1);
    // Alternate master: the device counts wait states and drives the acknowledge
    wr(CSD_CTL_BASE + 8'h14, 32'h3083);
    alt <= 1'b1;
    xfer(32'h0050_0000, 1'b1);
    chk(cyc, 5);
    chk(ack_seen, 1'b1);
    // Synchronised async acknowledge ends alternate and core transfers early
    aack <= 1'b1;
    xfer(32'h0050_0000, 1'b1);
    chk(cyc, 2);
    alt <= 1'b0;
    ack_en <= 1'b0;
    xfer(32'h0050_0000, 1'b1);
    chk(cyc, 2);
    aack <= 1'b0;
    // Both DRAM banks match: only DRAM 0 is flagged and no bank is selected
    wr(CSD_DORG_BASE, 32'h0090_0000);
    wr(CSD_DORG_BASE + 8'h04, 32'h0090_0000);
    wr(CSD_DIGN_BASE, 32'h0000_0001);
    wr(CSD_DIGN_BASE + 8'h04, 32'h0000_0001);
    xfer(32'h0090_0000, 1'b1);
    chk(dram_seen, 2'h1);
    chk(sel_seen, 8'h00);
    // Long read from an 8-bit bank with burst on
    wr(CSD_ORG_BASE + 8'h1C, 32'h0070_0000);
    wr(CSD_CTL_BASE + 8'h1C, 32'h3950);
    xfer(32'h0070_0000, 1'b1);
    chk(sel_seen, 8'h80);
    chk(cyc, 2);
    chk(burst_seen, 1'b1);
    chk(port_width, PW_8);
    finish_test();
  end
endmodule
